/* File: audio_volume_pkg.sv */
`default_nettype none
package audio_volume_pkg;

  // ****************************************
  // stream
  // ****************************************
  localparam int SAMPLE_W = 24;
  localparam int NUM_CH = 6;
  localparam int NUM_ADC_CH = 2;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic [SAMPLE_W-1:0] adc_left;
    logic [SAMPLE_W-1:0] adc_right;
    logic [SAMPLE_W-1:0] dac1_left;
    logic [SAMPLE_W-1:0] dac1_right;
    logic [SAMPLE_W-1:0] dac2_left;
    logic [SAMPLE_W-1:0] dac2_right;
  } audio_frame_t;

  typedef enum logic [1:0] {
    DEEMPH_OFF,
    DEEMPH_48K,
    DEEMPH_44K1,
    DEEMPH_32K
  } deemph_mode_t;

  // ****************************************
  // gain codes and ramp
  // ****************************************
  localparam logic [7:0] ADC_GAIN_RESET = 8'h30;
  localparam logic [7:0] DAC_GAIN_RESET = 8'h18;
  localparam logic [9:0] LEVEL_MUTE = 10'h3FC;
  localparam logic [9:0] FINE_PER_OCT = 10'h030;
  localparam int ADC_BOOST_OCT = 4;
  localparam int DAC_BOOST_OCT = 2;
  localparam int MANT_FRAC = 16;
  localparam logic [1:0] SLOW_LAST_TICK = 2'h3;
  localparam logic [11:0] MUTE_MAX_LR = 12'h390;
  localparam logic [11:0] MUTE_MAX_LR_SLOW = 12'hE40;
  localparam int RECOVER_MS = 200;
  localparam int CLK_HZ = 25_000_000;
  localparam int RECOVER_CYCLES = RECOVER_MS * (CLK_HZ / 1000);

  // ****************************************
  // de-emphasis coefficients, q15
  // ****************************************
  localparam int COEF_FRAC = 15;
  localparam logic signed [15:0] DE48_B0 = 16'sh35D9;
  localparam logic signed [15:0] DE48_B1 = 16'shF64A;
  localparam logic signed [15:0] DE48_P = 16'sh53DD;
  localparam logic signed [15:0] DE44_B0 = 16'sh36F6;
  localparam logic signed [15:0] DE44_B1 = 16'shF85C;
  localparam logic signed [15:0] DE44_P = 16'sh50AE;
  localparam logic signed [15:0] DE32_B0 = 16'sh3BBC;
  localparam logic signed [15:0] DE32_B1 = 16'sh0138;
  localparam logic signed [15:0] DE32_P = 16'sh430C;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] ADC_GAIN_OFS = 8'h04;
  localparam logic [7:0] DAC_GAIN_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] LEVEL_OFS = 8'h10;
  localparam int ADC_SPEED_BIT = 0;
  localparam int DAC_SPEED_BIT = 1;
  localparam int ADC_MUTE_BIT = 2;
  localparam int DAC1_MUTE_BIT = 3;
  localparam int DAC2_MUTE_BIT = 4;
  localparam int DAC1_RUN_BIT = 5;
  localparam int DAC2_RUN_BIT = 6;
  localparam int SOFT_RESET_N_BIT = 7;
  localparam int ADC_RUN_BIT = 8;
  localparam int DEEMPH1_LSB = 9;
  localparam int DEEMPH2_LSB = 11;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_01E0;
  localparam logic [31:0] ADC_GAIN_REG_RESET = 32'h0000_3030;
  localparam logic [31:0] DAC_GAIN_REG_RESET = 32'h1818_1818;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // fine gain table, one octave in 48 steps
  // ****************************************
  localparam logic [16:0] STEP_RATIO = 17'h0FC54;
  typedef logic [16:0] gain_tab_t [48];

  function automatic gain_tab_t build_gain_tab();
    gain_tab_t tab;
    logic [33:0] acc;
    tab[0] = 17'h10000;
    for (int k = 1; k < 48; k++) begin
      acc = 34'(tab[k-1]) * 34'(STEP_RATIO);
      tab[k] = 17'(acc[32:16] + 17'(acc[15]));
    end
    return tab;
  endfunction : build_gain_tab

  localparam gain_tab_t GAIN_TAB = build_gain_tab();

  function automatic logic [SAMPLE_W-1:0] sat24(input logic signed [41:0] v);
    logic [SAMPLE_W-1:0] r;
    if (v > 42'sh000_007F_FFFF) r = 24'h7FFFFF;
    else if (v < -42'sh000_0080_0000) r = 24'h800000;
    else r = v[SAMPLE_W-1:0];
    return r;
  endfunction : sat24

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction : merge_strb

endpackage : audio_volume_pkg
`default_nettype wire

/* File: audio_volume_soft_mute.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// frame fifo
// ****************************************
module audio_fifo #(
  parameter int WIDTH = 144,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  wire logic [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));
  wire logic [PW-1:0] wr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
  wire logic [PW-1:0] rd_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge aclk) begin
    if (ce && push) mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr <= wr_inc;
      if (pop) rd_ptr <= rd_inc;
      count <= next_count;
      in_ready <= (next_count != CW'(DEPTH));
    end
  end
endmodule : audio_fifo

// ****************************************
// one channel: gain ramp, soft mute, de-emphasis
// ****************************************
module gain_channel import audio_volume_pkg::*; #(
  parameter int BOOST_OCT = ADC_BOOST_OCT,
  parameter logic [7:0] RESET_CODE = ADC_GAIN_RESET,
  parameter bit USE_DEEMPH = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic init_active,
  // settings
  input wire logic [7:0] gain_code,
  input wire logic mute,
  input wire logic run,
  input wire logic step,
  input wire logic lr_tick,
  input wire logic [11:0] mute_limit,
  input wire logic [1:0] deemph_sel,
  // samples
  input wire logic take,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out,
  output logic [9:0] level
);
  logic [11:0] mute_timer;
  logic signed [SAMPLE_W-1:0] x1;
  logic signed [SAMPLE_W-1:0] y1;

  wire logic [9:0] target = mute ? LEVEL_MUTE : {gain_code, 2'b00};
  wire logic mute_expired = run && mute && (mute_timer == mute_limit);
  wire logic up = run && step && (level < target);
  wire logic down = run && step && (level > target);

  // level to gain: octave shift plus fine mantissa
  wire logic [4:0] oct = 5'(level / FINE_PER_OCT);
  wire logic [5:0] frac = 6'(level % FINE_PER_OCT);
  wire logic [16:0] mant = GAIN_TAB[frac];
  wire logic [5:0] sh = 6'(int'(oct) + MANT_FRAC - BOOST_OCT);
  wire logic signed [41:0] prod = $signed(sample_in) * $signed({1'b0, mant});
  wire logic signed [41:0] scaled = prod >>> sh;
  wire logic silent = (level == LEVEL_MUTE) || !run;
  wire logic [SAMPLE_W-1:0] vol = silent ? '0 : sat24(scaled);

  // first order shelving section per selected rate
  wire logic signed [15:0] b0 = (deemph_sel == DEEMPH_48K) ? DE48_B0 :
                                (deemph_sel == DEEMPH_44K1) ? DE44_B0 : DE32_B0;
  wire logic signed [15:0] b1 = (deemph_sel == DEEMPH_48K) ? DE48_B1 :
                                (deemph_sel == DEEMPH_44K1) ? DE44_B1 : DE32_B1;
  wire logic signed [15:0] pole = (deemph_sel == DEEMPH_48K) ? DE48_P :
                                  (deemph_sel == DEEMPH_44K1) ? DE44_P : DE32_P;
  wire logic signed [41:0] acc = $signed(vol) * b0 + x1 * b1
                                 + y1 * pole;
  wire logic [SAMPLE_W-1:0] de_y = sat24(acc >>> COEF_FRAC);
  wire logic deemph_on = USE_DEEMPH && (deemph_sel != DEEMPH_OFF);
  wire logic [SAMPLE_W-1:0] next_sample = deemph_on ? de_y : vol;

  always_ff @(posedge aclk) begin
    if (!aresetn || init_active) begin
      mute_timer <= '0;
    end else if (ce) begin
      if (!mute) mute_timer <= '0;
      else if (run && lr_tick && !mute_expired) mute_timer <= 12'(mute_timer + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || init_active) begin
      level <= {RESET_CODE, 2'b00};
    end else if (ce) begin
      if (mute_expired) level <= LEVEL_MUTE;
      else if (up) level <= 10'(level + 1'b1);
      else if (down) level <= 10'(level - 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || init_active) begin
      sample_out <= '0;
      x1 <= '0;
      y1 <= '0;
    end else if (ce && take) begin
      sample_out <= next_sample;
      x1 <= $signed(vol);
      y1 <= $signed(de_y);
    end
  end
endmodule : gain_channel

// ****************************************
// top
// ****************************************
module audio_volume_soft_mute import audio_volume_pkg::*; #(
  parameter int RECOVER_CYCLES_P = RECOVER_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pins
  input wire logic init_reset_pin_n,
  input wire logic lr_clock,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sample frames in
  input wire logic in_valid,
  output logic in_ready,
  input wire audio_frame_t in_frame,
  // sample frames out
  output logic out_valid,
  input wire logic out_ready,
  output audio_frame_t out_frame
);
  localparam int RCW = $clog2(RECOVER_CYCLES_P + 1);

  logic init_s1, init_s2, lr_s1, lr_s2, lr_s3;
  logic [31:0] control_reg_one, adc_gain_codes, dac_gain_codes;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] tick_div;
  logic adc_mute_q;
  logic [RCW-1:0] recover_cnt;
  logic fifo_valid;
  audio_frame_t fifo_frame;
  logic [SAMPLE_W-1:0] ch_in [NUM_CH];
  logic [SAMPLE_W-1:0] ch_out [NUM_CH];
  logic [9:0] ch_level [NUM_CH];
  logic [7:0] ch_code [NUM_CH];
  logic [NUM_CH-1:0] ch_mute, ch_run, ch_step;
  logic [1:0] ch_deemph [NUM_CH];

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_s1 <= 1'b1;
      init_s2 <= 1'b1;
      lr_s1 <= 1'b0;
      lr_s2 <= 1'b0;
      lr_s3 <= 1'b0;
    end else if (ce) begin
      init_s1 <= init_reset_pin_n;
      init_s2 <= init_s1;
      lr_s1 <= lr_clock;
      lr_s2 <= lr_s1;
      lr_s3 <= lr_s2;
    end
  end

  wire logic init_active = !init_s2;
  wire logic lr_tick = lr_s2 && !lr_s3;

  // ****************************************
  // control fields
  // ****************************************
  wire logic adc_ramp_speed_sel = control_reg_one[ADC_SPEED_BIT];
  wire logic dac_ramp_speed_sel = control_reg_one[DAC_SPEED_BIT];
  wire logic adc_mute = control_reg_one[ADC_MUTE_BIT];
  wire logic dac_pair1_mute = control_reg_one[DAC1_MUTE_BIT];
  wire logic dac_pair2_mute = control_reg_one[DAC2_MUTE_BIT];
  wire logic dac_pair1_run = control_reg_one[DAC1_RUN_BIT];
  wire logic dac_pair2_run = control_reg_one[DAC2_RUN_BIT];
  wire logic system_soft_reset_n = control_reg_one[SOFT_RESET_N_BIT];
  wire logic adc_run = control_reg_one[ADC_RUN_BIT];
  wire logic [1:0] dac_pair1_deemph_sel = control_reg_one[DEEMPH1_LSB +: 2];
  wire logic [1:0] dac_pair2_deemph_sel = control_reg_one[DEEMPH2_LSB +: 2];
  wire logic [7:0] adc_left_gain_code = adc_gain_codes[7:0];
  wire logic [7:0] adc_right_gain_code = adc_gain_codes[15:8];
  wire logic [7:0] dac_pair1_left_gain_code = dac_gain_codes[7:0];
  wire logic [7:0] dac_pair1_right_gain_code = dac_gain_codes[15:8];
  wire logic [7:0] dac_pair2_left_gain_code = dac_gain_codes[23:16];
  wire logic [7:0] dac_pair2_right_gain_code = dac_gain_codes[31:24];
  wire logic dac1_active = dac_pair1_run && system_soft_reset_n;
  wire logic dac2_active = dac_pair2_run && system_soft_reset_n;

  // ****************************************
  // ramp step pacing
  // ****************************************
  wire logic slow_edge = lr_tick && (tick_div == SLOW_LAST_TICK);
  wire logic adc_step = adc_ramp_speed_sel ? slow_edge : lr_tick;
  wire logic dac_step = dac_ramp_speed_sel ? slow_edge : lr_tick;
  wire logic [11:0] adc_mute_limit =
    adc_ramp_speed_sel ? MUTE_MAX_LR_SLOW : MUTE_MAX_LR;
  wire logic [11:0] dac_mute_limit =
    dac_ramp_speed_sel ? MUTE_MAX_LR_SLOW : MUTE_MAX_LR;

  always_ff @(posedge aclk) begin
    if (!aresetn || init_active) tick_div <= '0;
    else if (ce && lr_tick) tick_div <= 2'(tick_div + 1'b1);
  end

  // after unmute the input path is still climbing back
  always_ff @(posedge aclk) begin
    if (!aresetn || init_active) begin
      adc_mute_q <= 1'b0;
      recover_cnt <= '0;
    end else if (ce) begin
      adc_mute_q <= adc_mute;
      if (adc_mute_q && !adc_mute) recover_cnt <= RCW'(RECOVER_CYCLES_P);
      else if (recover_cnt != '0) recover_cnt <= RCW'(recover_cnt - 1'b1);
    end
  end

  // ****************************************
  // frame path
  // ****************************************
  wire logic take = fifo_valid && (!out_valid || out_ready);

  audio_fifo #(
    .WIDTH($bits(audio_frame_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_frame),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_frame)
  );

  assign ch_in = '{fifo_frame.adc_left, fifo_frame.adc_right,
                   fifo_frame.dac1_left, fifo_frame.dac1_right,
                   fifo_frame.dac2_left, fifo_frame.dac2_right};
  assign ch_code = '{adc_left_gain_code, adc_right_gain_code,
                     dac_pair1_left_gain_code, dac_pair1_right_gain_code,
                     dac_pair2_left_gain_code, dac_pair2_right_gain_code};
  assign ch_mute = {dac_pair2_mute, dac_pair2_mute, dac_pair1_mute,
                    dac_pair1_mute, adc_mute, adc_mute};
  assign ch_run = {dac2_active, dac2_active, dac1_active, dac1_active,
                   adc_run, adc_run};
  assign ch_step = {dac_step, dac_step, dac_step, dac_step,
                    adc_step, adc_step};
  assign ch_deemph = '{2'h0, 2'h0, dac_pair1_deemph_sel, dac_pair1_deemph_sel,
                       dac_pair2_deemph_sel, dac_pair2_deemph_sel};

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam bit IS_ADC = (i < NUM_ADC_CH);
    gain_channel #(
      .BOOST_OCT(IS_ADC ? ADC_BOOST_OCT : DAC_BOOST_OCT),
      .RESET_CODE(IS_ADC ? ADC_GAIN_RESET : DAC_GAIN_RESET),
      .USE_DEEMPH(!IS_ADC)
    ) u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .init_active(init_active),
      .gain_code(ch_code[i]),
      .mute(ch_mute[i]),
      .run(ch_run[i]),
      .step(ch_step[i]),
      .lr_tick(lr_tick),
      .mute_limit(IS_ADC ? adc_mute_limit : dac_mute_limit),
      .deemph_sel(ch_deemph[i]),
      .take(take),
      .sample_in(ch_in[i]),
      .sample_out(ch_out[i]),
      .level(ch_level[i])
    );
  end

  assign out_frame = {ch_out[0], ch_out[1], ch_out[2],
                      ch_out[3], ch_out[4], ch_out[5]};

  always_ff @(posedge aclk) begin
    if (!aresetn) out_valid <= 1'b0;
    else if (ce && take) out_valid <= 1'b1;
    else if (ce && out_ready) out_valid <= 1'b0;
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  wire logic wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic wr_ctl = wr_go && (aw_addr[7:2] == CONTROL_OFS[7:2]);
  wire logic wr_adc = wr_go && (aw_addr[7:2] == ADC_GAIN_OFS[7:2]);
  wire logic wr_dac = wr_go && (aw_addr[7:2] == DAC_GAIN_OFS[7:2]);
  wire logic wr_hit = wr_ctl || wr_adc || wr_dac;
  wire logic adc_settled = (ch_level[0] == (adc_mute ? LEVEL_MUTE :
                            {adc_left_gain_code, 2'b00}))
                        && (ch_level[1] == (adc_mute ? LEVEL_MUTE :
                            {adc_right_gain_code, 2'b00}));
  wire logic dac1_silent = (ch_level[2] == LEVEL_MUTE) && (ch_level[3] == LEVEL_MUTE);
  wire logic dac2_silent = (ch_level[4] == LEVEL_MUTE) && (ch_level[5] == LEVEL_MUTE);
  wire logic [31:0] status_word = {28'h0, dac2_silent, dac1_silent,
                                   adc_settled, (recover_cnt != '0)};
  wire logic [31:0] level_word = {6'h0, ch_level[1], 6'h0, ch_level[0]};
  wire logic [5:0] rd_idx = s_axi_araddr[7:2];
  wire logic rd_hit = (rd_idx <= LEVEL_OFS[7:2]);
  wire logic [31:0] rd_word =
    (rd_idx == CONTROL_OFS[7:2]) ? control_reg_one :
    (rd_idx == ADC_GAIN_OFS[7:2]) ? adc_gain_codes :
    (rd_idx == DAC_GAIN_OFS[7:2]) ? dac_gain_codes :
    (rd_idx == STATUS_OFS[7:2]) ? status_word :
    (rd_idx == LEVEL_OFS[7:2]) ? level_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || init_active) begin
      control_reg_one <= CONTROL_RESET;
      adc_gain_codes <= ADC_GAIN_REG_RESET;
      dac_gain_codes <= DAC_GAIN_REG_RESET;
    end else if (ce) begin
      if (wr_ctl) control_reg_one <= merge_strb(control_reg_one, w_data, w_strb)
                                     & 32'h0000_1FFF;
      if (wr_adc) adc_gain_codes <= merge_strb(adc_gain_codes, w_data, w_strb)
                                    & 32'h0000_FFFF;
      if (wr_dac) dac_gain_codes <= merge_strb(dac_gain_codes, w_data, w_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : audio_volume_soft_mute
`default_nettype wire

/* File: audio_volume_soft_mute_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module volume_checker import audio_volume_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // frames
  input wire logic out_valid,
  input wire logic out_ready,
  input wire audio_frame_t out_frame
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_rd_latency: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write not closed");
  a_frame_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
    else $error("frame dropped");
endmodule : volume_checker
bind audio_volume_soft_mute volume_checker chk_i (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .out_valid,
  .out_ready, .out_frame);
`default_nettype wire

/* File: audio_volume_soft_mute_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module audio_volume_soft_mute_bench import audio_volume_pkg::*;;
  logic aclk = 0, aresetn = 0, ce = 1, init_reset_pin_n = 1, lr_clock;
  logic [2:0] lr_div = 3'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, e;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, in_valid = 0, out_ready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, in_ready, out_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  audio_frame_t in_frame = audio_frame_t'({6{24'h10_0000}}), out_frame;
  int err_count = 0, n_tests = 0, cyc = 0, n, m;
  audio_volume_soft_mute #(.RECOVER_CYCLES_P(50), .DEPTH(4)) uut (.aclk,
    .aresetn, .ce, .init_reset_pin_n, .lr_clock, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_valid, .in_ready, .in_frame, .out_valid, .out_ready, .out_frame);
  always #20 aclk = ~aclk;
  always @(posedge aclk) lr_div <= lr_div + 3'h1;
  assign lr_clock = lr_div[2];
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", s, x, g);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic tk(input int t);
    repeat (8 * t) @(posedge aclk);
  endtask : tk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CONTROL_OFS); chk("control", CONTROL_RESET, v);
    rd(ADC_GAIN_OFS); chk("adc gain", 32'h0000_3030, v);
    rd(DAC_GAIN_OFS); chk("dac gain", 32'h1818_1818, v);
    rd(LEVEL_OFS); chk("level", 32'h00C0_00C0, v);
    rd(8'h14); chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    for (int k = 0; k < 4; k++) begin
      e = CONTROL_RESET | 32'(k << 9) | 32'(k << 11);
      wr(CONTROL_OFS, e);
      rd(CONTROL_OFS); chk("deemph", e, v);
    end
    $display("reset and mode tests done");
    wr(CONTROL_OFS, CONTROL_RESET);
    wr(ADC_GAIN_OFS, 32'h0000_3031); tk(10);
    rd(LEVEL_OFS); chk("fast ramp", 32'h00C0_00C4, v);
    wr(CONTROL_OFS, 32'h0000_01E1); wr(ADC_GAIN_OFS, 32'h0000_3032); tk(8);
    rd(LEVEL_OFS); n = v[9:0];
    chk("slow ramp", 32'h1, 32'(n > 10'h0C4 && n < 10'h0C8));
    tk(24); rd(LEVEL_OFS); chk("slow end", 32'h00C0_00C8, v);
    $display("ramp tests done");
    wr(CONTROL_OFS, 32'h0000_01E4); tk(10);
    wr(CONTROL_OFS, CONTROL_RESET); tk(4); rd(LEVEL_OFS); n = v[9:0];
    chk("mute undo", 32'h1, 32'(n > 10'h0C8 && n < 10'h0D2));
    wr(ADC_GAIN_OFS, 32'h0000_3000); tk(200);
    wr(CONTROL_OFS, 32'h0000_01E4); tk(900);
    rd(LEVEL_OFS); chk("mute ramp", 32'h1, 32'(v[9:0] < LEVEL_MUTE));
    tk(20); rd(LEVEL_OFS); chk("mute cap", 32'(LEVEL_MUTE), 32'(v[9:0]));
    wr(CONTROL_OFS, CONTROL_RESET);
    rd(STATUS_OFS); chk("recover busy", 32'h1, 32'(v[0]));
    repeat (60) @(posedge aclk);
    rd(STATUS_OFS); chk("recover end", 32'h0, 32'(v[0]));
    $display("adc mute tests done");
    wr(DAC_GAIN_OFS, 32'h1818_2020); wr(CONTROL_OFS, 32'h0000_01E8); tk(930);
    rd(STATUS_OFS); chk("pair muted", 32'h1, 32'(v[2]));
    wr(CONTROL_OFS, 32'h0000_01C8);
    n = 0; m = 0;
    @(posedge aclk); in_valid <= 1'b1;
    repeat (8) begin @(posedge aclk); if (in_ready) n++; end
    in_valid <= 1'b0; out_ready <= 1'b1;
    chk("fifo refuse", 32'h1, 32'(n >= 4 && n < 8));
    repeat (20) begin
      @(posedge aclk);
      if (out_valid) begin
        m++;
        chk("muted out", 32'h0, 32'(out_frame.dac1_left));
        chk("live out", 32'h0010_0000, 32'(out_frame.dac2_left));
      end
    end
    chk("fifo drain", 32'(n), 32'(m));
    $display("dac mute and fifo tests done");
    @(posedge aclk); init_reset_pin_n <= 1'b0;
    repeat (4) @(posedge aclk); init_reset_pin_n <= 1'b1;
    rd(ADC_GAIN_OFS); chk("init adc", 32'h0000_3030, v);
    rd(DAC_GAIN_OFS); chk("init dac", 32'h1818_1818, v);
    rd(STATUS_OFS); chk("init mute", 32'h0, 32'(v[2]));
    $display("init reset tests done");
    give_verdict();
  end
endmodule : audio_volume_soft_mute_bench
`default_nettype wire
